// file: verilog/pcl_link.sv
`timescale 1ns/1ps
`include "pcl_params.svh"
module pcl_link #(
	parameter int unsigned WAKE_GAP_TX_CYC =
		`PCL_WAKE_GAP_TX_US * `PCL_CLK_MHZ,
	parameter int unsigned WAKE_GAP_MAX_CYC =
		`PCL_WAKE_GAP_MAX_US * `PCL_CLK_MHZ
)(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire pcl_pkg::pcl_av_req_t av_req_i,
	output logic [31:0] av_readdata_o,
	output logic av_waitrequest_o,
	input wire pcl_pkg::pcl_line_t [1:0] rx_i,
	output pcl_pkg::pcl_line_t tx_o,
	output logic [1:0] tx_en_o,
	output logic [1:0] term_en_o,
	input wire logic wake_select_input_i,
	input wire logic sleep_i,
	input wire pcl_pkg::pcl_wake_ev_t wake_event_i,
	output logic wake_o,
	output logic sleep_fallback_o,
	output logic [6:0] reg_rd_addr_o,
	input wire logic [15:0] reg_rd_data_i,
	output logic reg_wr_o,
	output logic [6:0] reg_wr_addr_o,
	output logic [15:0] reg_wr_data_o
);

	localparam logic [6:0] BLANK = 7'(`PCL_BLANK_CYC);
	localparam logic [6:0] DBL = 7'(`PCL_DBL_CYC);
	localparam logic [7:0] LEN_BIT = 8'(`PCL_BIT_CYC);
	localparam logic [7:0] LOBE = 8'(`PCL_LOBE_CYC);
	localparam logic [5:0] LAST_BIT = 6'(`PCL_FRAME_BITS - 1);

	function automatic logic [7:0] pcl_crc8(input logic [39:0] d);
		logic [7:0] c;
		c = `PCL_CRC_INIT;
		for (int i = 39; i >= 0; i--)
		begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `PCL_CRC_POLY : 8'h00);
		end
		return c;
	endfunction : pcl_crc8

	// ----------------------------------------------------------------
	// Symbol decoders, index 0 lower port, 1 upper port
	// ----------------------------------------------------------------
	logic [1:0] rx_sv;
	pcl_pkg::pcl_sym_t rx_sym [2];

	for (genvar gp = 0; gp < 2; gp++)
	begin : g_port
		logic [1:0] s1_q, s2_q, s3_q;
		logic [6:0] gap_q;
		logic pend_q, ph_q, sv_q;
		pcl_pkg::pcl_sym_t sym_q;
		logic start;

		always_ff @(posedge mclk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				s1_q <= 2'h0;
				s2_q <= 2'h0;
				s3_q <= 2'h0;
			end
			else
			begin
				s1_q <= {rx_i[gp].pos, rx_i[gp].neg};
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
		end

		// Second lobe of a pulse falls inside the blank window
		assign start = (|(s2_q & ~s3_q)) && (gap_q >= BLANK);

		always_ff @(posedge mclk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				gap_q <= 7'h7f;
				pend_q <= 1'b0;
				ph_q <= 1'b0;
				sv_q <= 1'b0;
				sym_q <= pcl_pkg::SYM_ONE;
			end
			else
			begin
				sv_q <= 1'b0;
				if (gap_q != 7'h7f)
					gap_q <= gap_q + 7'h01;
				if (start)
				begin
					gap_q <= 7'h00;
					ph_q <= s2_q[1];
					pend_q <= !(pend_q && gap_q < DBL);
					if (pend_q)
					begin
						sv_q <= 1'b1;
						if (gap_q < DBL)
							sym_q <= ph_q ? pcl_pkg::SYM_OPEN : pcl_pkg::SYM_CLOSE;
						else
							sym_q <= ph_q ? pcl_pkg::SYM_ONE : pcl_pkg::SYM_ZERO;
					end
				end
				else if (pend_q && gap_q == DBL)
				begin
					sv_q <= 1'b1;
					pend_q <= 1'b0;
					sym_q <= ph_q ? pcl_pkg::SYM_ONE : pcl_pkg::SYM_ZERO;
				end
			end
		end

		assign rx_sv[gp] = sv_q;
		assign rx_sym[gp] = sym_q;
	end

	// ----------------------------------------------------------------
	// Frame assembly
	// ----------------------------------------------------------------
	logic in_frame_q, fr_port_q;
	logic [5:0] fr_cnt_q;
	logic [47:0] fr_sh_q;
	logic acc_p, acc_v, fr_end, fr_ok, fr_bad;
	pcl_pkg::pcl_sym_t acc_s;
	pcl_pkg::pcl_frame_t fr;

	// Lower port wins when both open together
	assign acc_p = in_frame_q ? fr_port_q : !rx_sv[0];
	assign acc_v = rx_sv[acc_p];
	assign acc_s = rx_sym[acc_p];
	assign fr = pcl_pkg::pcl_frame_t'(fr_sh_q);
	assign fr_end = acc_v && acc_s == pcl_pkg::SYM_CLOSE && in_frame_q;
	assign fr_ok = fr_end && fr_cnt_q == 6'(`PCL_FRAME_BITS)
		&& pcl_crc8(fr_sh_q[47:8]) == fr.crc;
	assign fr_bad = fr_end && !fr_ok && !sleep_i;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			in_frame_q <= 1'b0;
			fr_port_q <= 1'b0;
			fr_cnt_q <= 6'h00;
			fr_sh_q <= 48'h0;
		end
		else if (acc_v)
		begin
			unique case (acc_s)
				pcl_pkg::SYM_OPEN:
				begin
					in_frame_q <= 1'b1;
					fr_port_q <= acc_p;
					fr_cnt_q <= 6'h00;
				end
				pcl_pkg::SYM_CLOSE:
					in_frame_q <= 1'b0;
				pcl_pkg::SYM_ONE, pcl_pkg::SYM_ZERO:
				begin
					if (in_frame_q)
					begin
						fr_sh_q <= {fr_sh_q[46:0], acc_s == pcl_pkg::SYM_ONE};
						if (fr_cnt_q != 6'h3f)
							fr_cnt_q <= fr_cnt_q + 6'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic [5:0] node_id_q;
	logic fwd_en_q, wsel_mask_q;
	logic valid_req, do_read, do_wr;

	assign valid_req = fr_ok && !sleep_i && !fr.rsp;
	assign do_read = valid_req && fr.cmd == pcl_pkg::CMD_READ
		&& fr.id == node_id_q;
	assign do_wr = valid_req && ((fr.cmd == pcl_pkg::CMD_WRITE
		&& fr.id == node_id_q) || fr.cmd == pcl_pkg::CMD_GLOBAL);

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_wr_o <= 1'b0;
			reg_wr_addr_o <= 7'h00;
			reg_wr_data_o <= 16'h0000;
		end
		else
		begin
			reg_wr_o <= do_wr;
			if (do_wr)
			begin
				reg_wr_addr_o <= fr.addr;
				reg_wr_data_o <= fr.data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	logic ack_q, wr_take, err_flag_q;
	logic [7:0] err_cnt_q;
	logic [3:0] msg_cnt_q;
	logic [15:0] mask_a_q, mask_b_q, mask_c_q;
	logic [31:0] rd_mux;
	logic [31:0] wd;
	logic [4:0] wa;

	// One wait state per access; data stands on the release edge
	assign av_waitrequest_o = (av_req_i.read || av_req_i.write) && !ack_q;
	assign wr_take = av_req_i.write && !av_waitrequest_o;
	assign wd = av_req_i.writedata;
	assign wa = av_req_i.address;

	always_comb
	begin
		rd_mux = 32'h0;
		unique case (wa)
			`PCL_REG_CTRL: rd_mux = {22'h0, wsel_mask_q, fwd_en_q, 2'h0,
				node_id_q};
			`PCL_REG_STAT: rd_mux = {16'h0, err_cnt_q, 7'h00, err_flag_q};
			`PCL_REG_MASK_A: rd_mux = {16'h0, mask_a_q};
			`PCL_REG_MASK_B: rd_mux = {16'h0, mask_b_q};
			`PCL_REG_MASK_C: rd_mux = {16'h0, mask_c_q};
			`PCL_REG_MSGC: rd_mux = {28'h0, msg_cnt_q};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_q <= 1'b0;
			av_readdata_o <= 32'h0;
		end
		else
		begin
			ack_q <= (av_req_i.read || av_req_i.write) && !ack_q;
			if (av_req_i.read && !ack_q)
				av_readdata_o <= rd_mux;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			node_id_q <= 6'h00;
			fwd_en_q <= 1'b0;
			wsel_mask_q <= 1'b0;
		end
		else
		begin
			if (wr_take && wa == `PCL_REG_CTRL)
			begin
				if (wd[5:0] != 6'h00)
					node_id_q <= wd[5:0];
				fwd_en_q <= wd[`PCL_CTRL_FWD];
				wsel_mask_q <= wd[`PCL_CTRL_WSEL_MASK];
			end
			if (do_wr && fr.addr == `PCL_INIT_REG)
			begin
				if (fr.data[5:0] != 6'h00)
					node_id_q <= fr.data[5:0];
				fwd_en_q <= fr.data[`PCL_INIT_FWD_BIT];
			end
		end
	end

	// Masks clear at reset so internal wake starts disabled
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mask_a_q <= 16'h0000;
			mask_b_q <= 16'h0000;
			mask_c_q <= 16'h0000;
		end
		else if (wr_take)
		begin
			if (wa == `PCL_REG_MASK_A)
				mask_a_q <= wd[15:0];
			if (wa == `PCL_REG_MASK_B)
				mask_b_q <= wd[15:0];
			if (wa == `PCL_REG_MASK_C)
				mask_c_q <= wd[15:0];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			err_flag_q <= 1'b0;
			err_cnt_q <= 8'h00;
		end
		else
		begin
			if (wr_take && wa == `PCL_REG_STAT && wd[`PCL_STAT_ERR])
				err_flag_q <= 1'b0;
			// Set after clear so a same-cycle error survives
			if (fr_bad)
			begin
				err_flag_q <= 1'b1;
				if (err_cnt_q != 8'hff)
					err_cnt_q <= err_cnt_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Wake handling
	// ----------------------------------------------------------------
	logic ws1_q, ws2_q, ws3_q, ev_q, ev_any, wk_pend_q;
	logic wake_req_q, wake_take;
	logic [1:0] wake_mask_q;
	logic [31:0] wk_cnt_q;
	logic wk_first;

	assign ev_any = |(wake_event_i.a & mask_a_q) | |(wake_event_i.b & mask_b_q)
		| |(wake_event_i.c & mask_c_q);
	assign wk_first = sleep_i && fr_end && !wk_pend_q;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ws1_q <= 1'b0;
			ws2_q <= 1'b0;
			ws3_q <= 1'b0;
			ev_q <= 1'b0;
		end
		else
		begin
			ws1_q <= wake_select_input_i;
			ws2_q <= ws1_q;
			ws3_q <= ws2_q;
			ev_q <= ev_any;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wake_req_q <= 1'b0;
			wake_mask_q <= 2'h0;
		end
		else
		begin
			if (wake_take)
				wake_req_q <= 1'b0;
			if (ev_any && !ev_q)
			begin
				wake_req_q <= 1'b1;
				wake_mask_q <= 2'h3;
			end
			else if (wk_first)
			begin
				wake_req_q <= 1'b1;
				wake_mask_q <= fr_port_q ? 2'h1 : 2'h2;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wk_pend_q <= 1'b0;
			wk_cnt_q <= 32'h0;
			wake_o <= 1'b0;
			sleep_fallback_o <= 1'b0;
		end
		else
		begin
			wake_o <= sleep_i && (ws2_q ^ ws3_q) && !wsel_mask_q;
			sleep_fallback_o <= 1'b0;
			wk_cnt_q <= wk_cnt_q + 32'h1;
			if (wk_first)
			begin
				wk_pend_q <= 1'b1;
				wk_cnt_q <= 32'h0;
			end
			else if (wk_pend_q && fr_end)
			begin
				wk_pend_q <= 1'b0;
				wake_o <= 1'b1;
			end
			else if (wk_pend_q && wk_cnt_q >= WAKE_GAP_MAX_CYC)
			begin
				wk_pend_q <= 1'b0;
				sleep_fallback_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame transmitter
	// ----------------------------------------------------------------
	pcl_pkg::pcl_tx_st_t tx_st_q;
	logic tx_wake_q, tx_second_q, enc_busy_q, hold_v_q;
	logic [1:0] tx_mask_q, hold_mask_q, enc_mask_q;
	logic [31:0] tx_wait_q;
	logic [47:0] tx_sh_q;
	logic [5:0] tx_bit_q;
	logic [6:0] rsp_left_q, rd_addr_q;
	logic [7:0] enc_t_q, enc_len_q;
	pcl_pkg::pcl_sym_t hold_sym_q, enc_sym_q, fsm_sym;
	pcl_pkg::pcl_frame_t rf;
	logic fsm_req, fwd_ok, enc_go, enc_free;

	// Next symbol takes over on the last cycle, so a bit stays 100 cycles
	assign enc_free = !enc_busy_q || enc_t_q == enc_len_q - 8'h01;
	assign fsm_req = enc_free && (tx_st_q == pcl_pkg::TX_OPEN
		|| tx_st_q == pcl_pkg::TX_BITS || tx_st_q == pcl_pkg::TX_CLOSE);
	assign fsm_sym = tx_st_q == pcl_pkg::TX_OPEN ? pcl_pkg::SYM_OPEN
		: tx_st_q == pcl_pkg::TX_CLOSE ? pcl_pkg::SYM_CLOSE
		: tx_sh_q[47] ? pcl_pkg::SYM_ONE : pcl_pkg::SYM_ZERO;
	assign fwd_ok = fwd_en_q && node_id_q != 6'h00 && !sleep_i
		&& tx_st_q == pcl_pkg::TX_IDLE;
	assign enc_go = fsm_req || (enc_free && hold_v_q);
	assign wake_take = wake_req_q && tx_st_q == pcl_pkg::TX_IDLE;
	assign reg_rd_addr_o = rf.addr;

	always_comb
	begin
		rf = '0;
		rf.data = reg_rd_data_i;
		rf.rsp = 1'b1;
		rf.addr = rd_addr_q;
		rf.id = node_id_q;
		rf.cnt = msg_cnt_q;
		rf.cmd = pcl_pkg::CMD_READ;
		rf.crc = pcl_crc8(rf[47:8]);
	end

	// One-symbol hold absorbs decode skew between close and last bit
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hold_v_q <= 1'b0;
			hold_sym_q <= pcl_pkg::SYM_ONE;
			hold_mask_q <= 2'h0;
		end
		else
		begin
			if (!fsm_req && enc_free)
				hold_v_q <= 1'b0;
			if (acc_v && fwd_ok)
			begin
				hold_v_q <= 1'b1;
				hold_sym_q <= acc_s;
				hold_mask_q <= acc_p ? 2'h1 : 2'h2;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			msg_cnt_q <= 4'h0;
		else if (fsm_req && tx_st_q == pcl_pkg::TX_OPEN && !tx_wake_q)
			msg_cnt_q <= msg_cnt_q + 4'h1;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_st_q <= pcl_pkg::TX_IDLE;
			tx_wake_q <= 1'b0;
			tx_second_q <= 1'b0;
			tx_mask_q <= 2'h0;
			tx_wait_q <= 32'h0;
			tx_sh_q <= 48'h0;
			tx_bit_q <= 6'h00;
			rsp_left_q <= 7'h00;
			rd_addr_q <= 7'h00;
		end
		else
		begin
			unique case (tx_st_q)
				pcl_pkg::TX_IDLE:
				begin
					if (wake_take)
					begin
						tx_wake_q <= 1'b1;
						tx_second_q <= 1'b1;
						tx_mask_q <= wake_mask_q;
						tx_st_q <= pcl_pkg::TX_OPEN;
					end
					else if (do_read)
					begin
						tx_wake_q <= 1'b0;
						rsp_left_q <= (fr.data[6:0] == 7'h00) ? 7'h01
							: fr.data[6:0];
						rd_addr_q <= fr.addr;
						tx_mask_q <= fr_port_q ? 2'h2 : 2'h1;
						tx_wait_q <= `PCL_RESP_LAT_CYC;
						tx_st_q <= pcl_pkg::TX_WAIT;
					end
				end
				pcl_pkg::TX_WAIT:
				begin
					if (!enc_busy_q && !hold_v_q)
					begin
						if (tx_wait_q == 32'h0)
						begin
							if (!tx_wake_q)
								tx_sh_q <= rf;
							tx_st_q <= pcl_pkg::TX_OPEN;
						end
						else
							tx_wait_q <= tx_wait_q - 32'h1;
					end
				end
				pcl_pkg::TX_OPEN:
				begin
					if (fsm_req)
					begin
						tx_bit_q <= 6'h00;
						tx_st_q <= tx_wake_q ? pcl_pkg::TX_CLOSE
							: pcl_pkg::TX_BITS;
					end
				end
				pcl_pkg::TX_BITS:
				begin
					if (fsm_req)
					begin
						tx_sh_q <= {tx_sh_q[46:0], 1'b0};
						tx_bit_q <= tx_bit_q + 6'h01;
						if (tx_bit_q == LAST_BIT)
							tx_st_q <= pcl_pkg::TX_CLOSE;
					end
				end
				pcl_pkg::TX_CLOSE:
				begin
					if (fsm_req)
					begin
						tx_st_q <= pcl_pkg::TX_IDLE;
						if (tx_wake_q && tx_second_q)
						begin
							tx_second_q <= 1'b0;
							tx_wait_q <= WAKE_GAP_TX_CYC;
							tx_st_q <= pcl_pkg::TX_WAIT;
						end
						else if (!tx_wake_q && rsp_left_q > 7'h01)
						begin
							rsp_left_q <= rsp_left_q - 7'h01;
							rd_addr_q <= rd_addr_q + 7'h01;
							tx_wait_q <= `PCL_BURST_GAP_CYC;
							tx_st_q <= pcl_pkg::TX_WAIT;
						end
					end
				end
				default:
					tx_st_q <= pcl_pkg::TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pulse encoder, one symbol at a time on the ports set in its mask
	// ----------------------------------------------------------------
	logic [2:0] lobe, n_lobe;
	logic ph_pos, lobe_on;

	assign lobe = 3'(enc_t_q / LOBE);
	assign ph_pos = enc_sym_q == pcl_pkg::SYM_OPEN
		|| enc_sym_q == pcl_pkg::SYM_ONE;
	assign n_lobe = (enc_sym_q == pcl_pkg::SYM_OPEN
		|| enc_sym_q == pcl_pkg::SYM_CLOSE) ? 3'h4 : 3'h2;
	assign lobe_on = enc_busy_q && lobe < n_lobe;
	assign term_en_o = ~tx_en_o;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			enc_busy_q <= 1'b0;
			enc_t_q <= 8'h00;
			enc_len_q <= 8'h00;
			enc_sym_q <= pcl_pkg::SYM_ONE;
			enc_mask_q <= 2'h0;
			tx_o <= '0;
			tx_en_o <= 2'h0;
		end
		else
		begin
			tx_o.pos <= lobe_on && (lobe[0] ^ ph_pos);
			tx_o.neg <= lobe_on && !(lobe[0] ^ ph_pos);
			tx_en_o <= enc_busy_q ? enc_mask_q : 2'h0;
			if (enc_busy_q && !enc_go)
			begin
				enc_t_q <= enc_t_q + 8'h01;
				if (enc_t_q == enc_len_q - 8'h01)
					enc_busy_q <= 1'b0;
			end
			else if (enc_go)
			begin
				enc_busy_q <= 1'b1;
				enc_t_q <= 8'h00;
				enc_sym_q <= fsm_req ? fsm_sym : hold_sym_q;
				enc_mask_q <= fsm_req ? tx_mask_q : hold_mask_q;
				// Open carries its trailing pause; bit rate fixed by LEN_BIT
				enc_len_q <= ((fsm_req ? fsm_sym : hold_sym_q)
					== pcl_pkg::SYM_OPEN) ? 8'(LEN_BIT * 2) : LEN_BIT;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_term_half_dup: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		(tx_en_o & term_en_o) == 2'h0)
		else $error("Termination on while driving");
	a_zero_id_quiet: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		node_id_q == 6'h00 && acc_v |=> !hold_v_q || $past(hold_v_q))
		else $error("Zero identifier forwarded");
	a_fwd_opposite: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		acc_v && fwd_ok |=> hold_mask_q == ($past(acc_p) ? 2'h1 : 2'h2))
		else $error("Forward not to opposite port");
	a_err_count: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		fr_bad && err_cnt_q != 8'hff |=>
		err_flag_q && err_cnt_q == $past(err_cnt_q) + 8'h01)
		else $error("Link error not counted");
	a_write_silent: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		do_wr && tx_st_q == pcl_pkg::TX_IDLE && !wake_take
		|=> tx_st_q == pcl_pkg::TX_IDLE)
		else $error("Write produced a response");
	a_bad_silent: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		fr_bad && tx_st_q == pcl_pkg::TX_IDLE && !wake_take
		|=> tx_st_q == pcl_pkg::TX_IDLE)
		else $error("Corrupted frame answered");
	a_read_start: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		do_read && tx_st_q == pcl_pkg::TX_IDLE && !wake_take
		|=> tx_st_q == pcl_pkg::TX_WAIT && rsp_left_q != 7'h00
		&& tx_mask_q == ($past(fr_port_q) ? 2'h2 : 2'h1))
		else $error("Read not answered on arrival port");
	a_csb_wake: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		sleep_i && (ws2_q ^ ws3_q) && !wsel_mask_q |=> wake_o)
		else $error("Wake select edge missed");
	a_id_nonzero: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		$changed(node_id_q) |-> node_id_q != 6'h00)
		else $error("Zero identifier assigned");
	a_frame_len: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		tx_st_q == pcl_pkg::TX_BITS ##1 tx_st_q == pcl_pkg::TX_CLOSE
		|-> tx_bit_q == 6'(`PCL_FRAME_BITS))
		else $error("Response not 48 bits");

endmodule : pcl_link

// file: verilog/pcl_params.svh
`ifndef PCL_PARAMS_SVH
`define PCL_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and line timing
// ----------------------------------------------------------------
`define PCL_CLK_MHZ 200
`define PCL_BIT_NS 500
`define PCL_BIT_CYC (`PCL_BIT_NS * `PCL_CLK_MHZ / 1000)
`define PCL_LOBE_CYC (`PCL_BIT_CYC / 4)
`define PCL_BLANK_CYC (`PCL_LOBE_CYC * 3 / 2)
`define PCL_DBL_CYC (`PCL_LOBE_CYC * 3)
`define PCL_RESP_LAT_NS 2000
`define PCL_RESP_LAT_CYC (`PCL_RESP_LAT_NS * `PCL_CLK_MHZ / 1000)
`define PCL_BURST_GAP_NS 4000
`define PCL_BURST_GAP_CYC ((`PCL_BURST_GAP_NS * `PCL_CLK_MHZ + 999) / 1000)
`define PCL_WAKE_GAP_TX_US 1000
`define PCL_WAKE_GAP_MAX_US 2000

// ----------------------------------------------------------------
// Frame and check byte
// ----------------------------------------------------------------
`define PCL_FRAME_BITS 48
`define PCL_CRC_POLY 8'h2f
`define PCL_CRC_INIT 8'h42
`define PCL_INIT_REG 7'h01
`define PCL_INIT_FWD_BIT 6

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define PCL_REG_CTRL 5'h00
`define PCL_REG_STAT 5'h04
`define PCL_REG_MASK_A 5'h08
`define PCL_REG_MASK_B 5'h0c
`define PCL_REG_MASK_C 5'h10
`define PCL_REG_MSGC 5'h14
`define PCL_CTRL_FWD 8
`define PCL_CTRL_WSEL_MASK 9
`define PCL_STAT_ERR 0

`endif

// file: verilog/pcl_pkg.sv
package pcl_pkg;

	typedef struct packed {
		logic pos;
		logic neg;
	} pcl_line_t;

	typedef enum logic [1:0] {SYM_ONE, SYM_ZERO, SYM_OPEN, SYM_CLOSE} pcl_sym_t;

	typedef enum logic [1:0] {
		CMD_NOP = 2'h0,
		CMD_READ = 2'h1,
		CMD_WRITE = 2'h2,
		CMD_GLOBAL = 2'h3
	} pcl_cmd_t;

	typedef struct packed {
		logic [15:0] data;
		logic rsp;
		logic [6:0] addr;
		logic [1:0] rsv_a;
		logic [5:0] id;
		logic [3:0] cnt;
		logic [1:0] rsv_b;
		pcl_cmd_t cmd;
		logic [7:0] crc;
	} pcl_frame_t;

	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
	} pcl_wake_ev_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
	} pcl_av_req_t;

	typedef enum logic [2:0] {
		TX_IDLE, TX_WAIT, TX_OPEN, TX_BITS, TX_CLOSE
	} pcl_tx_st_t;

endpackage : pcl_pkg

// file: sim/pcl_bridge_model.sv
`timescale 1ns/1ps
module pcl_bridge_model (
	input wire logic mclk_i,
	output pcl_pkg::pcl_line_t [1:0] line_o
);
// ------
// Far-side pulse transmitter, quiet line is 00
// ------
initial line_o = '0;
task automatic seg(input int p, input logic [1:0] v, input int n);
	@(posedge mclk_i) line_o[p] <= v;
	repeat (n - 1) @(posedge mclk_i);
endtask : seg
task automatic pulse(input int p, input logic ph);
	seg(p, {ph, !ph}, 25);
	seg(p, {!ph, ph}, 25);
endtask : pulse
task automatic frame(input int p, input logic [47:0] f);
	pulse(p, 1'b1);
	pulse(p, 1'b1);
	seg(p, 2'b00, 100);
	for (int i = 47; i >= 0; i--)
	begin
		pulse(p, f[i]);
		seg(p, 2'b00, 50);
	end
	pulse(p, 1'b0);
	pulse(p, 1'b0);
	seg(p, 2'b00, 1);
endtask : frame
task automatic msg(input int p);
	pulse(p, 1'b1);
	pulse(p, 1'b1);
	seg(p, 2'b00, 100);
	pulse(p, 1'b0);
	pulse(p, 1'b0);
	seg(p, 2'b00, 1);
endtask : msg
endmodule : pcl_bridge_model

// file: sim/isolated_daisy_chain_link_bench.sv
`timescale 1ns/1ps
`include "pcl_params.svh"
module isolated_daisy_chain_link_bench;
// ------
// Harness
// ------
logic mclk_i = 0, rst_n_i = 0, sleep_i = 0, wsel = 0, wt, wk, fb;
logic up_seen = 0;
pcl_pkg::pcl_av_req_t req = '0;
pcl_pkg::pcl_wake_ev_t wev = '0;
logic [31:0] rd, q;
pcl_pkg::pcl_line_t tx;
pcl_pkg::pcl_line_t [1:0] rx;
logic [1:0] ten;
logic [6:0] ra, wa;
logic [15:0] rdat, wd;
int fail_count = 0, check_count = 0;
function automatic logic [15:0] regv(input logic [6:0] a);
	return {a, 9'h0a5};
endfunction : regv
assign rdat = regv(ra);
always #2.5 mclk_i = ~mclk_i;
always @(posedge mclk_i) if (ten[1] === 1'b1) up_seen <= 1'b1;
pcl_link #(.WAKE_GAP_TX_CYC(300), .WAKE_GAP_MAX_CYC(3000)) dut (
	.mclk_i, .rst_n_i, .av_req_i(req), .av_readdata_o(rd),
	.av_waitrequest_o(wt), .rx_i(rx), .tx_o(tx), .tx_en_o(ten),
	.term_en_o(), .wake_select_input_i(wsel), .sleep_i,
	.wake_event_i(wev), .wake_o(wk), .sleep_fallback_o(fb),
	.reg_rd_addr_o(ra), .reg_rd_data_i(rdat), .reg_wr_o(),
	.reg_wr_addr_o(wa), .reg_wr_data_o(wd)
);
pcl_bridge_model bm (.mclk_i, .line_o(rx));
// ------
// Helpers
// ------
task chk(input logic ok, input string m);
	check_count++;
	if (ok !== 1'b1)
	begin
		fail_count++;
		$display("ERROR %0t %s", $time, m);
	end
endtask : chk
task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
	@(posedge mclk_i) req <= '{read: !w, write: w, address: a, writedata: d};
	do @(posedge mclk_i); while (wt !== 1'b0);
	q = rd;
	req <= '0;
endtask : bus
function automatic logic [7:0] crc(input logic [39:0] m);
	logic [7:0] c;
	c = `PCL_CRC_INIT;
	for (int i = 39; i >= 0; i--)
		c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? `PCL_CRC_POLY : 8'h00);
	return c;
endfunction : crc
function automatic logic [47:0] mk(input logic [15:0] d,
	input logic [6:0] a, input logic [5:0] id, input logic [1:0] c);
	logic [39:0] m;
	m = {d, 1'b0, a, 2'b00, id, 4'h0, 2'b00, c};
	return {m, crc(m)};
endfunction : mk
task rsp(output logic [47:0] r, output int n);
	n = 0;
	while (ten[0] !== 1'b1 && n < 2000)
	begin
		@(negedge mclk_i);
		n++;
	end
	repeat (112) @(negedge mclk_i);
	for (int i = 47; i >= 0; i--)
	begin
		repeat (100) @(negedge mclk_i);
		r[i] = tx.pos;
	end
	// Return once the close symbol is off the line
	while (ten[0] === 1'b1) @(negedge mclk_i);
endtask : rsp
task rchk(input logic [47:0] r, input logic [6:0] a, input logic [3:0] c);
	chk(r[47:8] === {regv(a), 1'b1, a, 8'h00, c, 4'h1}, "rsp");
	chk(r[7:0] === crc(r[47:8]), "rsp crc");
endtask : rchk
task quiet(input int p);
	logic s;
	s = 1'b0;
	repeat (600) @(negedge mclk_i) s = s | ten[p];
	chk(s === 1'b0, "unexpected transmit");
endtask : quiet
// ------
// Scenarios
// ------
task t_regs;
	bus(0, `PCL_REG_CTRL, 0);
	chk(q === 32'h0, "ctrl reset");
	bus(1, `PCL_REG_MASK_A, 32'h00ff);
	bus(0, `PCL_REG_MASK_A, 0);
	chk(q === 32'h00ff, "mask a");
	bus(0, 5'h1c, 0);
	chk(q === 32'h0, "unmapped");
endtask : t_regs
task t_read;
	logic [47:0] r;
	int n;
	bm.frame(0, mk(16'h0002, 7'h7f, 6'h00, pcl_pkg::CMD_READ));
	rsp(r, n);
	chk(n >= 300 && n <= `PCL_RESP_LAT_CYC, "latency");
	rchk(r, 7'h7f, 4'h0);
	rsp(r, n);
	chk(n >= `PCL_BURST_GAP_CYC && n <= `PCL_BURST_GAP_CYC + 8,
		"burst gap");
	rchk(r, 7'h00, 4'h1);
	chk(up_seen === 1'b0, "id zero forwarded");
endtask : t_read
task t_bad;
	logic [47:0] r;
	int n;
	bm.frame(0, mk(16'h0, 7'h10, 6'h00, pcl_pkg::CMD_READ) ^ 48'h1);
	quiet(0);
	bm.frame(0, mk(16'h0, 7'h10, 6'h00, pcl_pkg::CMD_READ));
	rsp(r, n);
	rchk(r, 7'h10, 4'h2);
	bus(0, `PCL_REG_STAT, 0);
	chk(q[15:0] === 16'h0101, "error count");
	bus(1, `PCL_REG_STAT, 32'h1);
	bus(0, `PCL_REG_STAT, 0);
	chk(q[15:0] === 16'h0100, "flag clear");
endtask : t_bad
task t_write;
	bm.frame(0, mk(16'h0045, `PCL_INIT_REG, 6'h00, pcl_pkg::CMD_WRITE));
	quiet(0);
	chk(wa === `PCL_INIT_REG && wd === 16'h0045, "chain write");
	bus(0, `PCL_REG_CTRL, 0);
	chk(q[8:0] === 9'h105, "id and forward");
endtask : t_write
task t_fwd;
	up_seen <= 1'b0;
	bm.frame(0, mk(16'h0, 7'h0, 6'h09, pcl_pkg::CMD_NOP));
	quiet(0);
	chk(up_seen === 1'b1, "not forwarded");
	bus(1, `PCL_REG_CTRL, 32'h5);
	up_seen <= 1'b0;
	bm.frame(0, mk(16'h0, 7'h0, 6'h09, pcl_pkg::CMD_NOP));
	quiet(1);
	chk(up_seen === 1'b0, "isolated");
endtask : t_fwd
task t_wake;
	int n;
	n = 0;
	@(posedge mclk_i) sleep_i <= 1'b1;
	@(posedge mclk_i) wsel <= 1'b1;
	while (wk !== 1'b1 && n < 20)
	begin
		@(negedge mclk_i);
		n++;
	end
	chk(wk === 1'b1, "no wake");
endtask : t_wake
task t_chain_wake;
	int n;
	logic lo;
	n = 0;
	lo = 1'b0;
	up_seen <= 1'b0;
	bm.msg(0);
	while (fb !== 1'b1 && n < 3200)
	begin
		@(negedge mclk_i);
		lo = lo | ten[0];
		n++;
	end
	chk(up_seen === 1'b1 && lo === 1'b0, "wake not opposite only");
	chk(fb === 1'b1 && n > 2600, "no fall back to sleep");
endtask : t_chain_wake
task t_int_wake;
	int n;
	n = 0;
	@(posedge mclk_i) wev <= '{a: 16'h0001, b: 16'h0000, c: 16'h0000};
	while (ten !== 2'h3 && n < 20)
	begin
		@(negedge mclk_i);
		n++;
	end
	chk(ten === 2'h3, "internal wake not on both ports");
endtask : t_int_wake
task complete_run;
	$display("checks %0d errors %0d", check_count, fail_count);
	if (fail_count == 0 && check_count > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask : complete_run
initial
begin
	repeat (80000) @(posedge mclk_i);
	fail_count++;
	complete_run;
end
initial
begin
	repeat (3) @(posedge mclk_i);
	rst_n_i <= 1'b1;
	t_regs;
	t_read;
	t_bad;
	t_write;
	t_fwd;
	t_wake;
	t_chain_wake;
	t_int_wake;
	complete_run;
end
endmodule : isolated_daisy_chain_link_bench
